// [logic/islp_top.sv]
`default_nettype none
// Behaviour
// R1 - Final Sleep byte is 86h from master; device acknowledges it.
// R2 - SDA released only after ninth rising SCL, never at its falling edge.
// R3 - Sleep entry begins at ninth rising SCL; SDA floats while asleep.
// R4 - SDA rising while SCL high is a STOP, even from sleep release.
// R5 - Master may ignore the STOP caused by the sleep release.
// R6 - Master may drive SDA low itself from the ninth rising SCL.
// R7 - Master allows up to 400 us recovery from Sleep.
module islp_top
  import islp_pkg::*;
#(
  parameter int unsigned REC_CNT = REC_CYCLES
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic seq_armed,
  output logic      sleep_o,
  output logic      ready_o,
  output logic      stop_seen
);

  logic [1:0]        pins_s;
  logic              scl_s;
  logic              sda_s;
  logic              scl_q;
  logic              sda_q;
  islp_ev_t          ev;
  islp_state_t       state_q;
  islp_state_t       state_d;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic              oe_q;
  logic              oe_d;
  logic              stop_q;
  logic [REC_W-1:0]  rec_q;
  logic              byte_done;
  logic              is_sleep_id;
  logic              rec_done;
  logic              ack_take;
  logic              ack_skip;
  logic              sleep_d;
  logic              ready_d;
  logic              sleep_q;
  logic              ready_q;

  // ==========================================================
  // State class decode
  function automatic logic st_awake(input islp_state_t s);
    logic a;
    case (s)
      ST_IDLE, ST_RECV, ST_ACK: begin
        a = 1'b1;
      end
      default: begin
        a = 1'b0;
      end
    endcase
    return a;
  endfunction

  // ==========================================================
  // Pin synchronisers
  islp_sync #(.W(2)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .en   (clk_en),
    .d    ({scl_i, sda_i}),
    .q    (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ==========================================================
  // Bus event decode
  assign ev.scl_rise = scl_s & ~scl_q;
  assign ev.scl_fall = ~scl_s & scl_q;
  assign ev.start    = scl_s & scl_q & sda_q & ~sda_s;
  assign ev.stop     = scl_s & scl_q & ~sda_q & sda_s; // R4

  assign byte_done   = (bit_cnt_q == BITS_PER_BYTE);
  assign is_sleep_id = (shift_q == SLEEP_ID) & seq_armed; // R1
  assign rec_done    = (rec_q == REC_W'(REC_CNT - 1));
  assign ack_take    = ev.scl_fall & byte_done & is_sleep_id; // R1
  assign ack_skip    = ev.scl_fall & byte_done & ~is_sleep_id;

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    oe_d    = oe_q;
    case (state_q)
      ST_IDLE: begin
        oe_d = 1'b0;
        if (ev.start) begin
          state_d = ST_RECV;
        end
      end
      ST_RECV: begin
        if (ev.stop) begin
          state_d = ST_IDLE;
        end else if (ev.start) begin
          state_d = ST_RECV;
        end else if (ack_take) begin
          state_d = ST_ACK;
          oe_d    = 1'b1; // R1
        end else if (ack_skip) begin
          state_d = ST_IDLE;
        end
      end
      ST_ACK: begin
        // Release waits for the ninth SCL rise
        if (ev.scl_rise) begin
          state_d = ST_SLEEP; // R3
          oe_d    = 1'b0;     // R2
        end else if (ev.stop) begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      end
      ST_SLEEP: begin
        oe_d = 1'b0; // R3
        if (ev.start) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        oe_d = 1'b0;
        if (rec_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        oe_d    = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      oe_q    <= oe_d;
    end
  end

  // ==========================================================
  // Status registers; sleep and ready loaded from next state, stop from the bus event
  assign sleep_d = (state_d == ST_SLEEP);
  assign ready_d = st_awake(state_d);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_q  <= 1'b0;
      sleep_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (clk_en) begin
      stop_q  <= ev.stop; // R4
      sleep_q <= sleep_d; // R3
      ready_q <= ready_d;
    end
  end

  // ==========================================================
  // Bit shifter, sampled on rising SCL
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= BIT_CNT_RST;
      shift_q   <= SHIFT_RST;
    end else if (clk_en) begin
      // Count holds at eight until the eighth SCL fall, then clears once out of ST_RECV
      if (ev.start || state_q != ST_RECV) begin
        bit_cnt_q <= BIT_CNT_RST;
      end else if (ev.scl_rise && !byte_done) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= {shift_q[6:0], sda_s};
      end
    end
  end

  // ==========================================================
  // Wake recovery counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_q <= REC_CNT_RST;
    end else if (clk_en) begin
      if (state_q == ST_WAKE) begin
        rec_q <= rec_q + REC_W'(1);
      end else begin
        rec_q <= REC_CNT_RST;
      end
    end
  end

  assign sda_o     = 1'b0;
  assign sda_oe    = oe_q;
  assign sleep_o   = sleep_q;
  assign ready_o   = ready_q;
  assign stop_seen = stop_q;

endmodule
`default_nettype wire

// [logic/islp_pkg.sv]
`default_nettype none
package islp_pkg;

  // ==========================================================
  // Bus constants
  localparam logic [7:0]  SLEEP_ID       = 8'h86;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]  BIT_CNT_RST    = 4'h0;
  localparam logic [7:0]  SHIFT_RST      = 8'h00;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned T_REC_US       = 400;
  localparam int unsigned REC_CYCLES     = T_REC_US * CLK_MHZ;
  localparam int unsigned REC_W          = 17;
  localparam logic [16:0] REC_CNT_RST    = 17'h00000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } islp_ev_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RECV  = 5'b00010,
    ST_ACK   = 5'b00100,
    ST_SLEEP = 5'b01000,
    ST_WAKE  = 5'b10000
  } islp_state_t;

endpackage
`default_nettype wire

// [logic/islp_sync.sv]
`default_nettype none
module islp_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // Two-stage synchroniser, pins idle high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '1;
      q      <= '1;
    end else if (en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// [test/islp_checker.sv]
`default_nettype none
module islp_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic seq_armed,
  input wire logic sleep_o,
  input wire logic ready_o,
  input wire logic stop_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ack; $rose(sda_oe) |-> seq_armed; endproperty
  a_ack: assert property (p_ack) else $error("ack unarmed");
  property p_rel; $fell(sda_oe) |-> scl_i; endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_ent; $rose(sleep_o) |-> $fell(sda_oe); endproperty
  a_ent: assert property (p_ent) else $error("bad entry");
  property p_flt; sleep_o |-> !sda_oe && !ready_o; endproperty
  a_flt: assert property (p_flt) else $error("no float");
  property p_stp; scl_i && $rose(sda_i) |-> ##[2:6] stop_seen; endproperty
  a_stp: assert property (p_stp) else $error("stop missed");
endmodule
bind islp_top islp_checker u_chk (.clk, .nrst, .scl_i, .sda_i, .sda_oe,
  .seq_armed, .sleep_o, .ready_o, .stop_seen);
`default_nettype wire

// [test/islp_master.sv]
`default_nettype none
module islp_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 6;
  logic ack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    scl = 1'b0;
    sda_low = 1'b0;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_low = 1'b1;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask
  // Stop seen on bus never aborts a byte here
  task automatic put_byte(input logic [7:0] b, input logic hold);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      w(Q);
      scl = 1'b1;
      w(2 * Q);
      scl = 1'b0;
      w(Q);
    end
    sda_low = 1'b0;
    w(Q);
    scl = 1'b1;
    ack = sda;
    sda_low = hold & ~sda;
    w(2 * Q);
    scl = 1'b0;
    w(Q);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_low = 1'b0;
    w(2 * Q);
  endtask
endmodule
`default_nettype wire

// [test/islp_top_tb.sv]
`default_nettype none
module islp_top_tb
  import islp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REC = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic armed = 1'b0;
  logic en = 1'b1;
  logic scl, m_low, sda_o, sda_oe, sleep_o, ready_o, stop_seen;
  wire logic sda = ~(m_low | (sda_oe & ~sda_o));
  int errors = 0;
  int total_checks = 0;
  int stops = 0;
  always #2 clk = ~clk;
  always @(negedge clk) if (stop_seen === 1'b1) stops++;
  islp_top #(.REC_CNT(REC)) uut (.clk, .nrst, .clk_en(en), .scl_i(scl),
    .sda_i(sda), .sda_o, .sda_oe, .seq_armed(armed), .sleep_o, .ready_o,
    .stop_seen);
  islp_master m (.clk, .sda, .scl, .sda_low(m_low));
  // ==========
  // Checks
  task automatic chk(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic wake();
    m.start();
    chk("wake", 1'b0, sleep_o);
    chk("rec", 1'b0, ready_o);
    m.w(REC + 10);
    chk("ready", 1'b1, ready_o);
    m.stop();
  endtask
  task automatic t_refuse();
    armed = 1'b0;
    m.start();
    m.put_byte(SLEEP_ID, 1'b0);
    chk("nack", 1'b1, m.ack);
    m.stop();
    armed = 1'b1;
    m.start();
    m.put_byte(8'h87, 1'b0);
    chk("nack", 1'b1, m.ack);
    chk("awake", 1'b0, sleep_o);
    m.stop();
  endtask
  task automatic t_sleep(input logic hold);
    int s;
    m.start();
    s = stops;
    m.put_byte(SLEEP_ID, hold);
    chk("ack", 1'b0, m.ack);
    chk("sleep", 1'b1, sleep_o);
    chk("float", 1'b0, sda_oe);
    chk("drive", 1'b0, sda_o);
    chk("stop", !hold, stops == s + 1);
    wake();
  endtask
  task automatic t_freeze();
    m.start();
    m.put_byte(SLEEP_ID, 1'b1);
    en = 1'b0;
    m.start();
    en = 1'b1;
    m.w(5);
    chk("frozen", 1'b1, sleep_o);
    wake();
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    m.w(5);
    t_refuse();
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_freeze();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
